/* File: core/fmbm_top.sv */
// float-mode background light monitor with APB register slave
//
// Function
// R1 - in slot A subtract cycles each result above the slot A threshold advances its counter.
// R2 - slot A limit code 0 never flags, codes 1, 2 and 3 flag after 1, 4 and 16 exceedances.
// R3 - status bits 3:0 flag slot A channels 1 to 4 once the selected count is reached.
// R4 - status bits 7:4 flag slot B channels 1 to 4 once the slot B count is reached.
// R5 - a read of the status register clears every flag that the read returned, except a flag that is set again in that same cycle.
// R6 - slot B has its own limit field in bits 15:14, where code 0 keeps slot B flags clear.
// R7 - thresholds, limit fields and flags reset to zero, so flagging starts disabled.
// R8 - in slot B subtract cycles each result above the slot B threshold advances its counter.
// R9 - slot B limit codes decode like slot A: 1, 4 and 16 exceedances.
// R10 - every channel of every slot has its own counter that saturates at the limit.
`timescale 1ns/1ps
`default_nettype none

module fmbm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fmbm_pkg::ADDR_W-1:0] paddr,
    input wire logic [fmbm_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [fmbm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fmbm_pkg::fmbm_sample_s sample,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // limit decoding

    function automatic logic [fmbm_pkg::CNT_W-1:0] lim_decode(
        input logic [1:0] code
    );
        logic [fmbm_pkg::CNT_W-1:0] cnt;
        cnt = fmbm_pkg::CNT_ZERO;
        case (code)
            fmbm_pkg::LIM_NEVER: begin
                cnt = fmbm_pkg::CNT_ZERO;
            end
            fmbm_pkg::LIM_CODE_ONE: begin
                cnt = fmbm_pkg::CNT_ONE;
            end
            fmbm_pkg::LIM_CODE_FOUR: begin
                cnt = fmbm_pkg::CNT_FOUR;
            end
            fmbm_pkg::LIM_CODE_SIXTEEN: begin
                cnt = fmbm_pkg::CNT_SIXTEEN;
            end
            default: begin
                cnt = fmbm_pkg::CNT_ZERO;
            end
        endcase
        return cnt;
    endfunction : lim_decode

    ////////////////////////////////////////////////////////////////////////////
    // state

    fmbm_pkg::fmbm_apb_state_e state;
    fmbm_pkg::fmbm_apb_state_e next_state;
    logic [fmbm_pkg::REG_W-1:0] cfg_a;
    logic [fmbm_pkg::REG_W-1:0] cfg_b;
    logic [fmbm_pkg::FLAG_W-1:0] mask;
    logic [fmbm_pkg::FLAG_W-1:0] flags;
    logic [fmbm_pkg::CNT_W-1:0] cnt [fmbm_pkg::NUM_CNT];

    logic [fmbm_pkg::REG_W-1:0] next_cfg_a;
    logic [fmbm_pkg::REG_W-1:0] next_cfg_b;
    logic [fmbm_pkg::FLAG_W-1:0] next_mask;
    logic [fmbm_pkg::FLAG_W-1:0] next_flags;
    logic [fmbm_pkg::DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic next_irq;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire access = psel && penable;
    wire done = (state == fmbm_pkg::FMBM_ST_RESP) && access;
    wire hit_status = (paddr == fmbm_pkg::ADDR_STATUS);
    wire hit_cfg_a = (paddr == fmbm_pkg::ADDR_CFG_A);
    wire hit_cfg_b = (paddr == fmbm_pkg::ADDR_CFG_B);
    wire hit_mask = (paddr == fmbm_pkg::ADDR_MASK);
    wire mapped = hit_status || hit_cfg_a || hit_cfg_b || hit_mask;
    wire wr_done = done && pwrite && mapped;
    wire wr_cfg_a = wr_done && hit_cfg_a;
    wire wr_cfg_b = wr_done && hit_cfg_b;
    wire wr_mask = wr_done && hit_mask;
    // the returned status word is still held in prdata at completion
    wire rd_status = done && !pwrite && hit_status;

    // byte lanes: only the low two lanes hold register bits
    wire [fmbm_pkg::REG_W-1:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [fmbm_pkg::REG_W-1:0] wdata16 = pwdata[fmbm_pkg::REG_W-1:0];

    assign next_cfg_a = wr_cfg_a ? ((cfg_a & ~lane_mask) | (wdata16 & lane_mask)) : cfg_a;
    assign next_cfg_b = wr_cfg_b ? ((cfg_b & ~lane_mask) | (wdata16 & lane_mask)) : cfg_b;
    assign next_mask = (wr_mask && pstrb[0]) ? pwdata[fmbm_pkg::FLAG_W-1:0] : mask;

    always_comb begin
        next_state = state;
        case (state)
            fmbm_pkg::FMBM_ST_IDLE: begin
                if (access) begin
                    next_state = fmbm_pkg::FMBM_ST_RESP;
                end
            end
            fmbm_pkg::FMBM_ST_RESP: begin
                next_state = fmbm_pkg::FMBM_ST_IDLE;
            end
            default: begin
                next_state = fmbm_pkg::FMBM_ST_IDLE;
            end
        endcase
    end

    // read data is captured in the wait cycle so prdata comes from a flop
    wire load_rd = (state == fmbm_pkg::FMBM_ST_IDLE) && access && !pwrite;
    wire [fmbm_pkg::DATA_W-1:0] rd_word =
        hit_status ? {{(fmbm_pkg::DATA_W-fmbm_pkg::FLAG_W){1'b0}}, flags} :
        hit_cfg_a ? {{(fmbm_pkg::DATA_W-fmbm_pkg::REG_W){1'b0}}, cfg_a} :
        hit_cfg_b ? {{(fmbm_pkg::DATA_W-fmbm_pkg::REG_W){1'b0}}, cfg_b} :
        hit_mask ? {{(fmbm_pkg::DATA_W-fmbm_pkg::FLAG_W){1'b0}}, mask} :
        fmbm_pkg::RDATA_RST;
    assign next_prdata = load_rd ? rd_word : prdata;
    assign next_pslverr = (state == fmbm_pkg::FMBM_ST_IDLE) && access && !mapped;

    ////////////////////////////////////////////////////////////////////////////
    // per-slot settings

    wire [fmbm_pkg::THR_W-1:0] thr_a = cfg_a[fmbm_pkg::THR_MSB:fmbm_pkg::THR_LSB]; // R1
    wire [fmbm_pkg::THR_W-1:0] thr_b = cfg_b[fmbm_pkg::THR_MSB:fmbm_pkg::THR_LSB]; // R8
    wire [fmbm_pkg::CNT_W-1:0] lim_a = lim_decode(cfg_a[fmbm_pkg::LIM_MSB:fmbm_pkg::LIM_LSB]); // R2
    wire [fmbm_pkg::CNT_W-1:0] lim_b = lim_decode(cfg_b[fmbm_pkg::LIM_MSB:fmbm_pkg::LIM_LSB]); // R6 R9

    wire exceed_a = sample.valid && !sample.slot_b && (sample.result > thr_a); // R1
    wire exceed_b = sample.valid && sample.slot_b && (sample.result > thr_b); // R8

    // clear of flags the read returned; prdata still holds that word
    wire [fmbm_pkg::FLAG_W-1:0] clr_flags =
        rd_status ? prdata[fmbm_pkg::FLAG_W-1:0] : fmbm_pkg::FLAG_RST; // R5

    logic [fmbm_pkg::NUM_CNT-1:0] set_flags;

    ////////////////////////////////////////////////////////////////////////////
    // exceedance counters, one per channel per slot

    genvar gi;
    generate
        for (gi = 0; gi < fmbm_pkg::NUM_CNT; gi++) begin : g_cnt
            localparam bit IS_B = (gi >= fmbm_pkg::NUM_CH);
            localparam logic [1:0] CH = 2'(gi % fmbm_pkg::NUM_CH);
            wire [fmbm_pkg::CNT_W-1:0] lim = IS_B ? lim_b : lim_a;
            wire ex = (IS_B ? exceed_b : exceed_a) && (sample.chan == CH);
            // a new limit or threshold restarts the count for that slot
            wire restart = IS_B ? wr_cfg_b : wr_cfg_a;
            wire room = (cnt[gi] < lim);
            wire [fmbm_pkg::CNT_W-1:0] inc = cnt[gi] + fmbm_pkg::CNT_ONE;
            wire [fmbm_pkg::CNT_W-1:0] next_cnt =
                restart ? fmbm_pkg::CNT_ZERO :
                (ex && room) ? inc : cnt[gi]; // R10
            // limit zero never flags; saturated counter flags again on each exceedance
            assign set_flags[gi] = ex && !restart && (lim != fmbm_pkg::CNT_ZERO) &&
                                   (!room || (inc == lim)); // R2 R3 R4 R6 R9

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt[gi] <= fmbm_pkg::CNT_ZERO;
                end else begin
                    cnt[gi] <= next_cnt;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // status flags and interrupt

    // a set in the clearing cycle wins
    assign next_flags = (flags & ~clr_flags) | set_flags; // R3 R4 R5
    assign next_irq = |(next_flags & next_mask);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= fmbm_pkg::FMBM_ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= fmbm_pkg::RDATA_RST;
        end else begin
            state <= next_state;
            pready <= (next_state == fmbm_pkg::FMBM_ST_RESP);
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_a <= fmbm_pkg::CFG_RST; // R7
            cfg_b <= fmbm_pkg::CFG_RST; // R7
            mask <= fmbm_pkg::MASK_RST;
        end else begin
            cfg_a <= next_cfg_a;
            cfg_b <= next_cfg_b;
            mask <= next_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= fmbm_pkg::FLAG_RST; // R7
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            irq <= next_irq;
        end
    end

endmodule : fmbm_top

`default_nettype wire

/* File: pkg/fmbm_pkg.sv */
// package: register map, field layout and carriers of the background monitor
package fmbm_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned NUM_SLOT = 2;
    localparam int unsigned NUM_CNT = NUM_CH * NUM_SLOT;
    localparam int unsigned THR_W = 14;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned FLAG_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h04;
    localparam logic [7:0] IDX_CFG_A = 8'h16;
    localparam logic [7:0] IDX_CFG_B = 8'h1C;
    localparam logic [7:0] IDX_MASK = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CFG_A = {2'h0, IDX_CFG_A, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CFG_B = {2'h0, IDX_CFG_B, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};

    // config and status register fields
    localparam int unsigned THR_LSB = 0;
    localparam int unsigned THR_MSB = 13;
    localparam int unsigned LIM_LSB = 14;
    localparam int unsigned LIM_MSB = 15;
    localparam int unsigned FLAG_B_LSB = 4;

    // limit field codes and their exceedance counts
    localparam logic [1:0] LIM_NEVER = 2'h0;
    localparam logic [1:0] LIM_CODE_ONE = 2'h1;
    localparam logic [1:0] LIM_CODE_FOUR = 2'h2;
    localparam logic [1:0] LIM_CODE_SIXTEEN = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_FOUR = 5'h04;
    localparam logic [CNT_W-1:0] CNT_SIXTEEN = 5'h10;

    // reset values
    localparam logic [REG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
    localparam logic [FLAG_W-1:0] MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        FMBM_ST_IDLE = 2'b00,
        FMBM_ST_RESP = 2'b01
    } fmbm_apb_state_e;

    // one float-mode subtract-cycle ADC result
    typedef struct packed {
        logic valid;
        logic slot_b;
        logic [1:0] chan;
        logic [THR_W-1:0] result;
    } fmbm_sample_s;

endpackage : fmbm_pkg

/* File: tb/fmbm_monitor.sv */
// checker: port-level assertions of the background monitor
`timescale 1ns/1ps
`default_nettype none
module fmbm_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fmbm_pkg::ADDR_W-1:0] paddr,
    input wire logic [fmbm_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [fmbm_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fmbm_pkg::fmbm_sample_s sample,
    input wire logic irq
);
    wire logic done;
    wire logic rd_stat;
    wire logic wr_mask;
    wire logic is_cfg;
    wire logic mapped;
    assign done = psel && penable && pready;
    assign rd_stat = done && !pwrite && paddr == fmbm_pkg::ADDR_STATUS;
    assign wr_mask = done && pwrite && paddr == fmbm_pkg::ADDR_MASK;
    assign is_cfg = paddr == fmbm_pkg::ADDR_CFG_A || paddr == fmbm_pkg::ADDR_CFG_B;
    assign mapped = is_cfg || paddr == fmbm_pkg::ADDR_STATUS || paddr == fmbm_pkg::ADDR_MASK;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst_quiet; $rose(presetn) |-> !irq && !pready && prdata == 32'h0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
    property p_err_map; done |-> pslverr == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("bad error response");
    property p_stat_up; rd_stat |-> prdata[31:8] == 24'h0; endproperty
    a_stat_up: assert property (p_stat_up) else $error("status upper bits set");
    property p_cfg_up; done && !pwrite && is_cfg |-> prdata[31:16] == 16'h0; endproperty
    a_cfg_up: assert property (p_cfg_up) else $error("config upper bits set");
    property p_clear; rd_stat && !sample.valid && !$past(sample.valid) |=> !irq; endproperty
    a_clear: assert property (p_clear) else $error("flags kept after read");
    property p_irq_rise; $rose(irq) |-> $past(sample.valid) || $past(wr_mask); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("flag without sample");
    property p_irq_fall; $fell(irq) |-> $past(rd_stat) || $past(wr_mask); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("flag lost");
    property p_rd_hold; $changed(prdata) |-> pready && !pwrite; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : fmbm_monitor
bind fmbm_top fmbm_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .sample, .irq);
`default_nettype wire

/* File: tb/fmbm_top_test.sv */
// testbench: register, sample and interrupt scenarios of the background monitor
`timescale 1ns/1ps
`default_nettype none
module fmbm_top_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    fmbm_pkg::fmbm_sample_s sample = 18'h00000;
    int err_count = 0, checks = 0;
    always #2 pclk = ~pclk;
    fmbm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .sample, .irq);
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // ends past a falling edge so callers see settled flags
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // pready, read data and error are taken at the completing rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) err_count++;
        psel <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask : apb
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(e, rd);
    endtask : rdchk
    task smp(input logic b, input logic [1:0] c, input logic [13:0] r, input int k);
        repeat (k) begin
            @(posedge pclk);
            sample <= {1'b1, b, c, r};
        end
        @(posedge pclk);
        sample <= 18'h00000;
        @(negedge pclk);
    endtask : smp
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdchk(fmbm_pkg::ADDR_CFG_A, 32'h0);
        rdchk(fmbm_pkg::ADDR_CFG_B, 32'h0);
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h0);
        rdchk(fmbm_pkg::ADDR_MASK, 32'h0);
        chk(32'h0, {31'h0, irq});
    endtask : t_reset
    task t_map;
        apb(0, 12'h004, 32'h0);
        chk(32'h1, {31'h0, er});
        apb(1, fmbm_pkg::ADDR_STATUS, 32'h0000_00FF);
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h0);
    endtask : t_map
    task t_limits;
        logic [1:0] ch;
        logic [31:0] b;
        int n;
        for (int s = 0; s < 2; s++) begin
            for (int c = 1; c < 4; c++) begin
                n = (c == 1) ? 1 : (c == 2) ? 4 : 16;
                ch = 2'((c + s) % 4);
                b = 32'h1 << (s * 4 + ch);
                apb(1, s ? fmbm_pkg::ADDR_CFG_B : fmbm_pkg::ADDR_CFG_A, {16'h0, 2'(c), 14'h0100});
                apb(1, fmbm_pkg::ADDR_MASK, 32'h0000_00FF);
                smp(1'(s), ch, 14'h0100, 3);
                smp(1'(s), ch, 14'h0101, n - 1);
                rdchk(fmbm_pkg::ADDR_STATUS, 32'h0);
                smp(1'(s), ch, 14'h3FFF, 1);
                chk(32'h1, {31'h0, irq});
                rdchk(fmbm_pkg::ADDR_STATUS, b);
                chk(32'h0, {31'h0, irq});
                rdchk(fmbm_pkg::ADDR_STATUS, 32'h0);
                smp(1'(s), ch, 14'h3FFF, 1);
                rdchk(fmbm_pkg::ADDR_STATUS, b);
            end
        end
    endtask : t_limits
    task t_never;
        apb(1, fmbm_pkg::ADDR_CFG_A, 32'h0);
        apb(1, fmbm_pkg::ADDR_CFG_B, 32'h0);
        smp(0, 2'h0, 14'h3FFF, 20);
        smp(1, 2'h3, 14'h3FFF, 20);
        chk(32'h0, {31'h0, irq});
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h0);
    endtask : t_never
    task t_indep;
        apb(1, fmbm_pkg::ADDR_CFG_A, 32'h0000_8010);
        smp(0, 2'h0, 14'h0020, 3);
        smp(0, 2'h1, 14'h0020, 3);
        smp(0, 2'h0, 14'h0020, 1);
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h1);
        smp(0, 2'h1, 14'h0020, 1);
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h2);
    endtask : t_indep
    task t_mask;
        apb(1, fmbm_pkg::ADDR_MASK, 32'h0);
        apb(1, fmbm_pkg::ADDR_CFG_A, 32'h0000_4000);
        smp(0, 2'h2, 14'h0001, 1);
        chk(32'h0, {31'h0, irq});
        apb(1, fmbm_pkg::ADDR_MASK, 32'h0000_0004);
        chk(32'h1, {31'h0, irq});
        rdchk(fmbm_pkg::ADDR_STATUS, 32'h4);
        chk(32'h0, {31'h0, irq});
    endtask : t_mask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_map();
        t_limits();
        t_never();
        t_indep();
        t_mask();
        conclude();
    end
    // whole run is a few hundred cycles
    initial begin
        #100000;
        err_count++;
        conclude();
    end
endmodule : fmbm_top_test
`default_nettype wire
